// ===== logic/pao_regs.svh
`ifndef PAO_REGS_SVH
`define PAO_REGS_SVH
// register byte addresses
`define PAO_CTRL_ADDR       12'h000
`define PAO_PORT_ADDR       12'h004
`define PAO_PCEN_ADDR       12'h008
`define PAO_EXT_ADDR        12'h00c
`define PAO_PIN_ADDR        12'h010
`define PAO_OVR_ADDR        12'h014
// control register fields
`define PAO_CTRL_XMEM_BIT   0
`define PAO_CTRL_PUOFF_BIT  2
`define PAO_CTRL_PCIE_BIT   3
`define PAO_CTRL_SLEEP_BIT  4
// port register fields
`define PAO_PORT_OUT_LSB    0
`define PAO_PORT_DIR_LSB    8
// external memory register fields
`define PAO_EXT_ADDR_LSB    0
`define PAO_EXT_DATA_LSB    8
`define PAO_EXT_WR_BIT      16
`define PAO_EXT_APH_BIT     17
// reset values
`define PAO_CTRL_RST        5'h00
`define PAO_BYTE_RST        8'h00
`endif

// ===== logic/pao_pkg.sv
package pao_pkg;
   typedef struct packed
   {
      logic [7:0] pu_en;
      logic [7:0] pu_val;
      logic [7:0] dir_en;
      logic [7:0] dir_val;
      logic [7:0] ov_en;
      logic [7:0] ov_val;
      logic [7:0] ie_en;
      logic [7:0] ie_val;
   } pao_ovr_t;

   typedef struct packed
   {
      logic [7:0] drive_en;
      logic [7:0] drive_val;
      logic [7:0] pullup_en;
      logic [7:0] input_en;
   } pao_pad_t;
endpackage

// ===== logic/pao_port_a.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps

`include "pao_regs.svh"

module pao_port_a
   import pao_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [WIDTH-1:0]  pad_in,
   output logic      [WIDTH-1:0]  pad_out,
   output logic      [WIDTH-1:0]  pad_oe,
   output logic      [WIDTH-1:0]  pad_pullup,
   output logic      [WIDTH-1:0]  pin_change_line_n,
   output logic      [WIDTH-1:0]  ext_data_in
);

   logic [4:0]       ctrl_q;
   logic [WIDTH-1:0] pin_out_bit_q;
   logic [WIDTH-1:0] pin_direction_bit_q;
   logic [WIDTH-1:0] pcen_q;
   logic [WIDTH-1:0] ext_addr_bit_q;
   logic [WIDTH-1:0] ext_data_out_bit_q;
   logic             wr_strobe_q;
   logic             address_phase_active_q;
   logic [WIDTH-1:0] sync1_q;
   logic [WIDTH-1:0] sync2_q;
   logic [WIDTH-1:0] pin_q;
   logic [WIDTH-1:0] out_q;
   logic [WIDTH-1:0] oe_q;
   logic [WIDTH-1:0] pu_q;
   logic             ext_mem_enable;
   logic             global_pullup_off;
   logic             pin_change_group_enable;
   logic             sleep_mode;
   logic             wr_acc;
   pao_ovr_t         ovr;
   pao_pad_t         pad_d;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   assign ext_mem_enable          = ctrl_q[`PAO_CTRL_XMEM_BIT];
   assign global_pullup_off       = ctrl_q[`PAO_CTRL_PUOFF_BIT];
   assign pin_change_group_enable = ctrl_q[`PAO_CTRL_PCIE_BIT];
   assign sleep_mode              = ctrl_q[`PAO_CTRL_SLEEP_BIT];
   assign wr_acc                  = psel & penable & pwrite & clk_en;

   // zero-wait slave: access phase always completes at once
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `PAO_CTRL_RST;
      else if (wr_acc && hit(paddr, `PAO_CTRL_ADDR))
         ctrl_q <= pwdata[4:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_out_bit_q       <= `PAO_BYTE_RST;
         pin_direction_bit_q <= `PAO_BYTE_RST;
      end
      else if (wr_acc && hit(paddr, `PAO_PORT_ADDR))
      begin
         pin_out_bit_q       <= pwdata[`PAO_PORT_OUT_LSB +: WIDTH];
         pin_direction_bit_q <= pwdata[`PAO_PORT_DIR_LSB +: WIDTH];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pcen_q <= `PAO_BYTE_RST;
      else if (wr_acc && hit(paddr, `PAO_PCEN_ADDR))
         pcen_q <= pwdata[WIDTH-1:0];
   end

   // memory-interface bus cycle state, written over the APB register port
   // address, write data, write strobe and address phase flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_addr_bit_q         <= `PAO_BYTE_RST;
         ext_data_out_bit_q     <= `PAO_BYTE_RST;
         wr_strobe_q            <= 1'b0;
         address_phase_active_q <= 1'b0;
      end
      else if (wr_acc && hit(paddr, `PAO_EXT_ADDR))
      begin
         ext_addr_bit_q         <= pwdata[`PAO_EXT_ADDR_LSB +: WIDTH];
         ext_data_out_bit_q     <= pwdata[`PAO_EXT_DATA_LSB +: WIDTH];
         wr_strobe_q            <= pwdata[`PAO_EXT_WR_BIT];
         address_phase_active_q <= pwdata[`PAO_EXT_APH_BIT];
      end
   end

   // pads are asynchronous: two flops before use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= `PAO_BYTE_RST;
         sync2_q <= `PAO_BYTE_RST;
      end
      else if (clk_en)
      begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_q <= `PAO_BYTE_RST;
      else if (clk_en)
         pin_q <= sync2_q & pad_d.input_en;
   end

   assign pin_change_line_n = pin_q;
   assign ext_data_in       = pin_q;

   // override generation, identical per pin
   genvar n;
   generate
      for (n = 0; n < WIDTH; n++)
      begin : g_pin
         assign ovr.pu_en[n]   = ext_mem_enable;
         assign ovr.pu_val[n]  = ~(wr_strobe_q | address_phase_active_q)
                                 & pin_out_bit_q[n];
         assign ovr.dir_en[n]  = ext_mem_enable;
         assign ovr.dir_val[n] = wr_strobe_q | address_phase_active_q;
         assign ovr.ov_en[n]   = ext_mem_enable;
         assign ovr.ov_val[n]  = address_phase_active_q ? ext_addr_bit_q[n]
                                 : (ext_data_out_bit_q[n] & wr_strobe_q);
         assign ovr.ie_en[n]   = pin_change_group_enable & pcen_q[n];
         assign ovr.ie_val[n]  = 1'b1;

         assign pad_d.drive_en[n]  = ovr.dir_en[n] ? ovr.dir_val[n]
                                     : pin_direction_bit_q[n];
         assign pad_d.drive_val[n] = ovr.ov_en[n] ? ovr.ov_val[n] : pin_out_bit_q[n];
         // global off beats the override too
         assign pad_d.pullup_en[n] = ~global_pullup_off
                                     & (ovr.pu_en[n] ? ovr.pu_val[n]
                                        : (~pin_direction_bit_q[n] & pin_out_bit_q[n]));
         assign pad_d.input_en[n]  = ovr.ie_en[n] ? ovr.ie_val[n] : ~sleep_mode;
      end
   endgenerate

   // registered pad controls keep data outputs glitch-free
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_q <= `PAO_BYTE_RST;
         oe_q  <= `PAO_BYTE_RST;
         pu_q  <= `PAO_BYTE_RST;
      end
      else if (clk_en)
      begin
         out_q <= pad_d.drive_val & pad_d.drive_en;
         oe_q  <= pad_d.drive_en;
         pu_q  <= pad_d.pullup_en & ~pad_d.drive_en;
      end
   end

   assign pad_out    = out_q;
   assign pad_oe     = oe_q;
   assign pad_pullup = pu_q;

   // read mux; unmapped addresses read zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (hit(paddr, `PAO_CTRL_ADDR))
         prdata[4:0] = ctrl_q;
      else if (hit(paddr, `PAO_PORT_ADDR))
      begin
         prdata[`PAO_PORT_OUT_LSB +: WIDTH] = pin_out_bit_q;
         prdata[`PAO_PORT_DIR_LSB +: WIDTH] = pin_direction_bit_q;
      end
      else if (hit(paddr, `PAO_PCEN_ADDR))
         prdata[WIDTH-1:0] = pcen_q;
      else if (hit(paddr, `PAO_EXT_ADDR))
      begin
         prdata[`PAO_EXT_ADDR_LSB +: WIDTH] = ext_addr_bit_q;
         prdata[`PAO_EXT_DATA_LSB +: WIDTH] = ext_data_out_bit_q;
         prdata[`PAO_EXT_WR_BIT]            = wr_strobe_q;
         prdata[`PAO_EXT_APH_BIT]           = address_phase_active_q;
      end
      else if (hit(paddr, `PAO_PIN_ADDR))
         prdata[WIDTH-1:0] = pin_q;
      else if (hit(paddr, `PAO_OVR_ADDR))
      begin
         prdata[7:0]   = oe_q;
         prdata[15:8]  = out_q;
         prdata[23:16] = pu_q;
         prdata[31:24] = pad_d.input_en;
      end
   end

endmodule // pao_port_a

// ===== sim/pao_chk.sv
`timescale 1ns/1ps
module pao_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pad_pullup,
   input wire logic [7:0]  pin_change_line_n,
   input wire logic [7:0]  ext_data_in
);
   logic [31:0] c_q;
   logic [31:0] p_q;
   logic [31:0] e_q;
   logic        go;
   assign go = psel & penable & pwrite & clk_en;
   // shadow copies; pads trail them by one edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c_q <= '0;
         p_q <= '0;
         e_q <= '0;
      end
      else if (go)
      begin
         if (paddr == 12'h000) c_q <= pwdata;
         if (paddr == 12'h004) p_q <= pwdata;
         if (paddr == 12'h00c) e_q <= pwdata;
      end
   end
   default clocking @(posedge pclk); endclocking
   // frozen clock enable stalls the pads as well
   default disable iff (!presetn || !clk_en);
   chk_pullup_off_all: assert property ($past(c_q[2]) |-> pad_pullup == 8'h00)
      else $error("pull-up on while disabled");
   chk_xmem_drive: assert property ($past(c_q[0]) |->
      pad_oe == {8{$past(e_q[16] | e_q[17])}}) else $error("driver enable wrong");
   chk_addr_out: assert property ($past(c_q[0] & e_q[17]) |-> pad_out == $past(e_q[7:0]))
      else $error("address not on pads");
   chk_wdata_out: assert property ($past(c_q[0] & e_q[16] & !e_q[17]) |->
      pad_out == $past(e_q[15:8])) else $error("write data not on pads");
   chk_ovr_pullup: assert property ($past(c_q[0] & !c_q[2]) |-> pad_pullup ==
      ($past(e_q[16] | e_q[17]) ? 8'h00 : $past(p_q[7:0]))) else $error("pull-up ovr");
   chk_plain_dir: assert property ($past(!c_q[0]) |-> pad_oe == $past(p_q[15:8]))
      else $error("plain direction wrong");
   chk_plain_pullup: assert property ($past(!c_q[0] & !c_q[2]) |->
      pad_pullup == $past(~p_q[15:8] & p_q[7:0])) else $error("plain pull-up");
   chk_din_fanout: assert property (pin_change_line_n == ext_data_in)
      else $error("input fan-out differs");
   chk_sleep_clamp: assert property ($past(c_q[4] & !c_q[3]) |-> pin_change_line_n == 8'h00)
      else $error("sleep did not clamp input");
endmodule // pao_chk
bind pao_port_a pao_chk pao_chk_inst (.pclk, .presetn, .clk_en, .paddr, .psel, .penable,
   .pwrite, .pwdata, .pad_out, .pad_oe, .pad_pullup, .pin_change_line_n, .ext_data_in);

// ===== sim/pao_ext_mem.sv
`timescale 1ns/1ps
module pao_ext_mem
(
   input wire logic       pclk,
   input wire logic       ale,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup,
   output logic     [7:0] pad_in
);
   logic [7:0] mem_q [256];
   logic [7:0] adr_q;
   logic       tgl_q = 1'b0;
   always_ff @(posedge pclk)
   begin
      tgl_q <= ~tgl_q;
      if (ale) adr_q <= pad_out;
      if (wr) mem_q[adr_q] <= pad_out;
   end
   // a floating line wanders so a stale level never passes
   always_comb
      for (int i = 0; i < 8; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : rd ? mem_q[adr_q][i] : pad_pullup[i] | tgl_q;
endmodule // pao_ext_mem

// ===== sim/pao_port_a_tb_top.sv
`timescale 1ns/1ps
module pao_port_a_tb_top;
   typedef struct packed {logic [31:0] c, p, e; logic [7:0] oe, o, pu;} pao_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic        pready;
   logic        pslverr;
   logic        ale = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  pad_in;
   logic [7:0]  pad_out;
   logic [7:0]  pad_oe;
   logic [7:0]  pad_pullup;
   logic [7:0]  pin_change_line_n;
   logic [7:0]  ext_data_in;
   int          mismatches = 0;
   int          num_checks = 0;
   pao_row_t    rows [8] = '{
      '{32'h0, 32'hf03c, 32'h0, 8'hf0, 8'h30, 8'h0c}, '{32'h4, 32'hf03c, 32'h0, 8'hf0, 8'h30, 8'h0},
      '{32'h1, 32'ha5, 32'h2c35a, 8'hff, 8'h5a, 8'h0}, '{32'h1, 32'ha5, 32'h1c35a, 8'hff, 8'hc3, 8'h0},
      '{32'h1, 32'ha5, 32'h3c35a, 8'hff, 8'h5a, 8'h0}, '{32'h1, 32'ha5, 32'hc35a, 8'h0, 8'h0, 8'ha5},
      '{32'h5, 32'ha5, 32'hc35a, 8'h0, 8'h0, 8'h0}, '{32'h0, 32'h0fa5, 32'h2c35a, 8'h0f, 8'h05, 8'ha0}};
   always #4 pclk = ~pclk;
   pao_port_a pao_port_a_inst (.pclk, .presetn, .clk_en, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pad_pullup,
      .pin_change_line_n, .ext_data_in);
   pao_ext_mem pao_ext_mem_inst (.pclk, .ale, .wr, .rd, .pad_out, .pad_oe, .pad_pullup, .pad_in);
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("Error t=%0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         mismatches++;
         summarize();
      end
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic step(input int n, input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (n) @(posedge pclk);
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h014, 32'h0);
      chk(rdat, 32'hff00_0000);
      foreach (rows[i])
      begin
         apb(1'b1, 12'h000, rows[i].c);
         apb(1'b1, 12'h004, rows[i].p);
         step(2, 12'h00c, rows[i].e);
         chk(pad_oe, rows[i].oe);
         chk(pad_out, rows[i].o);
         chk(pad_pullup, rows[i].pu);
      end
      apb(1'b1, 12'h018, 32'hffff_ffff);
      apb(1'b0, 12'h018, 32'h0);
      chk(rdat, 32'h0);
      chk(pslverr, 1'b0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h1);
      step(2, 12'h00c, 32'h2005a);
      ale <= 1'b1;
      @(posedge pclk);
      ale <= 1'b0;
      step(2, 12'h00c, 32'h1c35a);
      wr <= 1'b1;
      @(posedge pclk);
      wr <= 1'b0;
      apb(1'b1, 12'h00c, 32'h0);
      rd <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(pin_change_line_n, 8'hc3);
      chk(ext_data_in, 8'hc3);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdat, 32'hc3);
      apb(1'b1, 12'h008, 32'h0f);
      step(6, 12'h000, 32'h19);
      chk(pin_change_line_n, 8'h03);
      step(6, 12'h000, 32'h11);
      chk(ext_data_in, 8'h00);
      clk_en <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
      clk_en <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h11);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      chk(pad_oe, 8'h0);
      summarize();
   end
endmodule // pao_port_a_tb_top
